// *** common/fsp_defines.svh ***
// Purpose: Named offsets, fields, codes and timing counts of the flash self-programming controller.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

`define FSP_ADDR_CONTROL     12'h000
`define FSP_ADDR_KEY         12'h004
`define FSP_ADDR_TABLE_PAGE  12'h008
`define FSP_ADDR_TABLE_WRITE 12'h00c
`define FSP_ADDR_TABLE_READ  12'h010
`define FSP_ADDR_STATUS      12'h014

`define FSP_BIT_START        15
`define FSP_BIT_OP_WRITE_ENABLE         14
`define FSP_BIT_SEQERR       13
`define FSP_BIT_ERASE        6
`define FSP_OPSEL_HI         3
`define FSP_OPSEL_LO         0

// Table write/read command word: [15:0] effective address, [16] high half, [17] byte mode.
`define FSP_TW_HIGH_BIT      16
`define FSP_TW_BYTE_BIT      17

`define FSP_KEY_FIRST        8'h55
`define FSP_KEY_SECOND       8'haa

`define FSP_OP_BULK          4'hf
`define FSP_OP_GENERAL_SEG   4'hd
`define FSP_OP_SECURE_SEG    4'hc
`define FSP_OP_WORD          4'h3
`define FSP_OP_PAGE          4'h2
`define FSP_OP_ROW           4'h1

`define FSP_ROW_WORDS        64
`define FSP_PAGE_ROWS        8
`define FSP_ROW_BYTES        192
`define FSP_PAGE_BYTES       1536
`define FSP_FRC_HZ           7370000
`define FSP_ROW_FRC_CYCLES   11064
`define FSP_PCLK_HZ          40000000
`define FSP_TABLE_WR_CYCLES  2

`endif

// *** common/fsp_pkg.sv ***
// Purpose: Types shared by the flash self-programming controller and its bench.
// Assumes: Constants come from fsp_defines.svh.
// Notes:   Flash array port carries one command at a time.
package fsp_pkg;

   typedef enum logic [2:0] {
      FSP_KIND_NONE,
      FSP_KIND_ROW,
      FSP_KIND_WORD,
      FSP_KIND_PAGE,
      FSP_KIND_BULK,
      FSP_KIND_GENERAL,
      FSP_KIND_SECURE
   } fsp_kind_e;

   typedef struct packed {
      fsp_kind_e   kind;
      logic [23:0] addr;
      logic [23:0] data;
   } fsp_flash_cmd_s;

endpackage : fsp_pkg

// *** verilog/fsp_ctrl.sv ***
// Purpose: Run-time self-programming controller: holding buffer, unlock key, self-timed flash ops.
// Assumes: APB slave on pclk (40 MHz); timing derived from the fast RC oscillator count.
// Notes:   The core stall output stays high for the whole operation.
//
// Design decisions made here: register access over APB and the register addresses.
`include "fsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module fsp_ctrl #(
   parameter int  ROW_WORDS     = `FSP_ROW_WORDS,
   parameter int  ROW_CYCLES    = (`FSP_ROW_FRC_CYCLES * (`FSP_PCLK_HZ / 1000) + (`FSP_FRC_HZ / 1000) - 1)
                                  / (`FSP_FRC_HZ / 1000),
   parameter int  WORD_CYCLES   = ROW_CYCLES,
   parameter int  ERASE_CYCLES  = ROW_CYCLES
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                clk_en,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     core_stall,
   output fsp_pkg::fsp_flash_cmd_s  flash_cmd,
   output logic                     flash_cmd_valid
);
   import fsp_pkg::*;

   localparam int IDX_W = $clog2(ROW_WORDS);
   localparam int CNT_W = 32;

   initial begin
      if (ROW_WORDS < 2 || (ROW_WORDS & (ROW_WORDS - 1)) != 0)
         $error("ROW_WORDS must be a power of two");
      if (ROW_CYCLES < 1 || WORD_CYCLES < 1 || ERASE_CYCLES < 1)
         $error("operation lengths must be at least one cycle");
      if (ROW_CYCLES <= ROW_WORDS)
         $error("ROW_CYCLES must exceed ROW_WORDS so a row can stream");
   end

   typedef enum logic [1:0] {FSP_IDLE, FSP_BUSY, FSP_DONE} fsp_state_e;

   fsp_state_e         state;
   logic               start_bit;
   logic               op_write_enable;
   logic               seq_err;
   logic               erase_sel;
   logic [3:0]         op_sel;
   logic [7:0]         table_page;
   logic [1:0]         key_stage;
   logic [23:0]        buf_mem [ROW_WORDS];
   logic [23:0]        target_addr;
   logic [CNT_W-1:0]   op_count;
   logic [IDX_W-1:0]   commit_idx;
   logic               tw_wait;
   logic               rd_fresh;
   logic [23:0]        read_word;
   logic [15:0]        read_data;
   fsp_kind_e          kind;
   fsp_kind_e          run_kind;

   logic               acc;
   logic               wr_acc;
   logic               ctrl_wr;
   logic               key_wr;
   logic               tw_wr;
   logic               mapped;
   logic               start_req;
   logic               start_ok;
   logic [23:0]        tw_addr;
   logic [IDX_W-1:0]   tw_idx;
   logic               tw_high;
   logic               tw_byte;

   assign acc     = psel && penable && clk_en;
   assign wr_acc  = acc && pready && pwrite;
   assign ctrl_wr = wr_acc && paddr == `FSP_ADDR_CONTROL;
   assign key_wr  = wr_acc && paddr == `FSP_ADDR_KEY;
   assign tw_wr   = wr_acc && paddr == `FSP_ADDR_TABLE_WRITE;
   assign mapped  = paddr == `FSP_ADDR_CONTROL || paddr == `FSP_ADDR_KEY || paddr == `FSP_ADDR_TABLE_PAGE ||
                    paddr == `FSP_ADDR_TABLE_WRITE || paddr == `FSP_ADDR_TABLE_READ ||
                    paddr == `FSP_ADDR_STATUS;

   // Table writes take a second cycle, reads wait for data fetched while idle, and an operation or a freeze
   // holds the bus.
   assign pready  = clk_en && (state == FSP_IDLE) &&
                    !(psel && paddr == `FSP_ADDR_TABLE_WRITE && pwrite && !tw_wait) &&
                    !(psel && !pwrite && !rd_fresh);
   assign pslverr = psel && penable && !mapped;
   assign core_stall = state != FSP_IDLE;

   assign tw_addr = {table_page, pwdata[15:0]};
   assign tw_idx  = tw_addr[IDX_W:1];
   assign tw_high = pwdata[`FSP_TW_HIGH_BIT];
   assign tw_byte = pwdata[`FSP_TW_BYTE_BIT];

   assign start_req = ctrl_wr && pwdata[`FSP_BIT_START] && !start_bit;
   assign start_ok  = start_req && key_stage == 2'd2 && pwdata[`FSP_BIT_OP_WRITE_ENABLE] && kind != FSP_KIND_NONE;

   always_comb begin
      kind = FSP_KIND_NONE;
      if (pwdata[`FSP_BIT_ERASE]) begin
         case (pwdata[`FSP_OPSEL_HI:`FSP_OPSEL_LO])
            `FSP_OP_BULK:        kind = FSP_KIND_BULK;
            `FSP_OP_GENERAL_SEG: kind = FSP_KIND_GENERAL;
            `FSP_OP_SECURE_SEG:  kind = FSP_KIND_SECURE;
            `FSP_OP_PAGE:        kind = FSP_KIND_PAGE;
            default:             kind = FSP_KIND_NONE;
         endcase
      end else begin
         case (pwdata[`FSP_OPSEL_HI:`FSP_OPSEL_LO])
            `FSP_OP_WORD:        kind = FSP_KIND_WORD;
            `FSP_OP_ROW:         kind = FSP_KIND_ROW;
            default:             kind = FSP_KIND_NONE;
         endcase
      end
   end

   // Control fields.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_write_enable      <= 1'b0;
         erase_sel <= 1'b0;
         op_sel    <= 4'h0;
      end else if (ctrl_wr) begin
         op_write_enable      <= pwdata[`FSP_BIT_OP_WRITE_ENABLE];
         erase_sel <= pwdata[`FSP_BIT_ERASE];
         op_sel    <= pwdata[`FSP_OPSEL_HI:`FSP_OPSEL_LO];
      end
   end

   // Start bit: software can only set it, hardware clears it at completion.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         start_bit <= 1'b0;
      else if (clk_en) begin
         if (start_ok)
            start_bit <= 1'b1;
         else if (state == FSP_DONE)
            start_bit <= 1'b0;
      end
   end

   // Error flag: set on a start refused for the key or the write enable, cleared by an accepted start.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         seq_err <= 1'b0;
      else if (clk_en) begin
         if (start_req && !start_ok && kind != FSP_KIND_NONE)
            seq_err <= 1'b1;
         else if (start_req && (key_stage != 2'd2 || !pwdata[`FSP_BIT_OP_WRITE_ENABLE]))
            seq_err <= 1'b1;
         else if (start_ok)
            seq_err <= 1'b0;
      end
   end

   // Key stage: 1 after 55, 2 after 55 then aa; any other register write breaks the pair.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         key_stage <= 2'd0;
      else if (wr_acc) begin
         if (key_wr && pwdata[7:0] == `FSP_KEY_FIRST)
            key_stage <= 2'd1;
         else if (key_wr && pwdata[7:0] == `FSP_KEY_SECOND && key_stage == 2'd1)
            key_stage <= 2'd2;
         else
            key_stage <= 2'd0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         table_page <= 8'h00;
      else if (wr_acc && paddr == `FSP_ADDR_TABLE_PAGE)
         table_page <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tw_wait <= 1'b0;
      else if (clk_en)
         tw_wait <= psel && penable && paddr == `FSP_ADDR_TABLE_WRITE && pwrite && !tw_wait && state == FSP_IDLE;
   end

   // A read finishes only on data fetched while idle, never on a word captured during an operation.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rd_fresh <= 1'b0;
      else if (clk_en)
         rd_fresh <= psel && !pwrite && state == FSP_IDLE && !(penable && pready);
   end

   // Holding buffer; a table write never reaches the array.
   for (genvar g = 0; g < ROW_WORDS; g++) begin : g_buf
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            buf_mem[g] <= 24'hffffff;
         else if (tw_wr && tw_idx == IDX_W'(g)) begin
            if (tw_high) begin
               // The byte above bit 23 does not exist, so a byte write aimed at it is dropped.
               if (!(tw_byte && pwdata[0]))
                  buf_mem[g][23:16] <= pwdata[31:24];
            end else if (tw_byte && pwdata[0])
               buf_mem[g][15:8] <= pwdata[31:24];
            else if (tw_byte)
               buf_mem[g][7:0] <= pwdata[31:24];
            else
               buf_mem[g][15:0] <= pwdata[31:16];
         end
      end
   end

   // Last table address aims the operation.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         target_addr <= 24'h000000;
      else if (tw_wr)
         target_addr <= tw_addr;
   end

   // Sequencer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= FSP_IDLE;
         op_count   <= '0;
         commit_idx <= '0;
         run_kind   <= FSP_KIND_NONE;
      end else if (clk_en) begin
         case (state)
            FSP_IDLE: begin
               if (start_ok) begin
                  state      <= FSP_BUSY;
                  run_kind   <= kind;
                  commit_idx <= '0;
                  op_count   <= CNT_W'(kind == FSP_KIND_ROW ? ROW_CYCLES :
                                       kind == FSP_KIND_WORD ? WORD_CYCLES : ERASE_CYCLES);
               end
            end
            FSP_BUSY: begin
               if (commit_idx != IDX_W'(ROW_WORDS - 1))
                  commit_idx <= commit_idx + 1'b1;
               if (op_count <= 1)
                  state <= FSP_DONE;
               else
                  op_count <= op_count - 1'b1;
            end
            FSP_DONE: state <= FSP_IDLE;
            default:  state <= FSP_IDLE;
         endcase
      end
   end

   // Flash array command: row streams one word per cycle from the row base, others issue once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cmd       <= '0;
         flash_cmd_valid <= 1'b0;
      end else if (clk_en) begin
         flash_cmd_valid <= 1'b0;
         if (state == FSP_BUSY && run_kind == FSP_KIND_ROW && op_count > CNT_W'(ROW_CYCLES - ROW_WORDS)) begin
            flash_cmd_valid <= 1'b1;
            flash_cmd.kind  <= run_kind;
            flash_cmd.addr  <= {target_addr[23:IDX_W+1], commit_idx, 1'b0};
            flash_cmd.data  <= buf_mem[commit_idx];
         end else if (state == FSP_BUSY && run_kind != FSP_KIND_ROW && op_count == CNT_W'(
                      run_kind == FSP_KIND_WORD ? WORD_CYCLES : ERASE_CYCLES)) begin
            flash_cmd_valid <= 1'b1;
            flash_cmd.kind  <= run_kind;
            flash_cmd.addr  <= run_kind == FSP_KIND_PAGE ?
                               {target_addr[23:IDX_W+4], {(IDX_W+4){1'b0}}} : target_addr;
            flash_cmd.data  <= buf_mem[target_addr[IDX_W:1]];
         end
      end
   end

   // The buffer read-back shows what the next commit would write.
   assign read_word = buf_mem[target_addr[IDX_W:1]];
   assign read_data = target_addr[0] ? {8'h00, read_word[23:16]} : read_word[15:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !pwrite && clk_en && !(penable && pready)) begin
         case (paddr)
            `FSP_ADDR_CONTROL:    prdata <= {16'h0000, start_bit, op_write_enable, seq_err, 6'h00, erase_sel, 2'b00, op_sel};
            `FSP_ADDR_TABLE_PAGE: prdata <= {24'h000000, table_page};
            `FSP_ADDR_TABLE_READ: prdata <= {16'h0000, read_data};
            `FSP_ADDR_STATUS:     prdata <= {29'h00000000, key_stage, core_stall};
            default:              prdata <= 32'h00000000;
         endcase
      end
   end

endmodule : fsp_ctrl
`default_nettype wire

// *** bench/fsp_ctrl_monitor.sv ***
// Purpose: Port-level checks on the flash self-programming controller.
// Assumes: Stall lengths count enabled cycles only; the bench freezes only while no transfer runs.
// Notes:   Bound into every fsp_ctrl instance.
`include "fsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_monitor #(
   parameter int ROW_CYCLES   = 100,
   parameter int WORD_CYCLES  = 100,
   parameter int ERASE_CYCLES = 100,
   parameter int ROW_WORDS    = 64
) (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    clk_en,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    core_stall,
   input wire fsp_pkg::fsp_flash_cmd_s flash_cmd,
   input wire logic                    flash_cmd_valid
);
   import fsp_pkg::*;
   localparam int M1 = WORD_CYCLES < ERASE_CYCLES ? WORD_CYCLES : ERASE_CYCLES;
   localparam int LO = ROW_CYCLES < M1 ? ROW_CYCLES : M1;
   localparam int H1 = WORD_CYCLES > ERASE_CYCLES ? WORD_CYCLES : ERASE_CYCLES;
   localparam int HI = (ROW_CYCLES > H1 ? ROW_CYCLES : H1) + ROW_WORDS + 8;
   logic        take;
   logic        ctl_start;
   logic [1:0]  kst;
   logic [15:0] scnt;
   assign take      = psel && penable && pready && pwrite;
   assign ctl_start = take && paddr == `FSP_ADDR_CONTROL && pwdata[15];
   // Key progress is rebuilt here so a refused start can be told from a legal one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) kst <= 2'd0;
      else if (clk_en && take) kst <= (paddr == `FSP_ADDR_KEY && pwdata[7:0] == 8'h55) ? 2'd1 :
                                      (paddr == `FSP_ADDR_KEY && pwdata[7:0] == 8'haa && kst == 2'd1) ? 2'd2 : 2'd0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) scnt <= 16'h0000;
      else if (clk_en) scnt <= core_stall ? scnt + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   stall_max_a: assert property (scnt <= HI)
      else $error("Core stall lasted too long.");
   stall_min_a: assert property ($fell(core_stall) |-> $past(scnt) >= LO - 1)
      else $error("Operation ended too early.");
   stall_cause_a: assert property ($rose(core_stall) |-> $past(ctl_start))
      else $error("Stall began without a start write.");
   stall_blocks_a: assert property (core_stall && psel && penable |-> !pready)
      else $error("Bus answered during an operation.");
   table_wait_a: assert property (psel && !penable && pwrite && paddr == `FSP_ADDR_TABLE_WRITE && !core_stall
      ##1 penable |-> !pready ##1 pready)
      else $error("Table write did not take two cycles.");
   key_zero_a: assert property (psel && penable && pready && !pwrite && paddr == `FSP_ADDR_KEY |-> prdata == 32'h0)
      else $error("Key register read non-zero.");
   cmd_in_op_a: assert property (flash_cmd_valid |-> core_stall || $past(core_stall))
      else $error("Flash command outside an operation.");
   cmd_kind_a: assert property (flash_cmd_valid |-> flash_cmd.kind != FSP_KIND_NONE)
      else $error("Flash command without a kind.");
   start_refused_a: assert property (ctl_start && kst != 2'd2 |=> !core_stall)
      else $error("Start accepted without unlock.");
   cover property ($rose(core_stall));
   cover property (ctl_start && kst != 2'd2);
   cover property (flash_cmd_valid && flash_cmd.kind == FSP_KIND_ROW);
endmodule : fsp_ctrl_monitor
bind fsp_ctrl fsp_ctrl_monitor #(.ROW_CYCLES(ROW_CYCLES), .WORD_CYCLES(WORD_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
   .ROW_WORDS(ROW_WORDS)) u_mon (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .core_stall(core_stall), .flash_cmd(flash_cmd), .flash_cmd_valid(flash_cmd_valid));
`default_nettype wire

// *** bench/fsp_core_model.sv ***
// Purpose: Processor core model issuing register and table writes over APB.
// Assumes: Tasks are entered just after a rising pclk edge.
// Notes:   Each transfer ends with one idle cycle on the bus.
`include "fsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   logic [31:0] rd_data;
   logic        rd_err;
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
   end
   // The request is held until pready is seen high; the bench timeout ends a hang.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task automatic unlock();
      xfer(1'b1, `FSP_ADDR_KEY, 32'h55);
      xfer(1'b1, `FSP_ADDR_KEY, 32'haa);
   endtask : unlock
   task automatic start(input logic [15:0] ctl);
      xfer(1'b1, `FSP_ADDR_CONTROL, {16'h0, ctl & 16'h7fff});
      unlock();
      xfer(1'b1, `FSP_ADDR_CONTROL, {16'h0, ctl});
      repeat (2) @(posedge pclk);
   endtask : start
   // Low data sits in [31:16], high byte in [31:24]; bits [17:16] carry the high and byte flags.
   task automatic load_row(input logic [7:0] page);
      xfer(1'b1, `FSP_ADDR_TABLE_PAGE, {24'h0, page});
      for (int i = 0; i < 64; i++) begin
         xfer(1'b1, `FSP_ADDR_TABLE_WRITE, {16'h1000 + 16'(i * 4), 16'(i * 2)});
         xfer(1'b1, `FSP_ADDR_TABLE_WRITE, {8'hc1, 8'h01, 16'(i * 2)});
      end
   endtask : load_row
endmodule : fsp_core_model
`default_nettype wire

// *** bench/fsp_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the flash self-programming controller.
// Assumes: Operation counts shortened to 100 cycles.
// Notes:   One test freezes an operation with clk_en low and checks that it resumes.
`include "fsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_tb_top;
   import fsp_pkg::*;
   typedef struct packed { logic [15:0] ctl; logic stall; } fsp_row_s;
   localparam fsp_row_s ROWS [11] = '{'{16'hc04f, 1'b1}, '{16'hc04d, 1'b1}, '{16'hc04c, 1'b1},
      '{16'hc042, 1'b1}, '{16'hc043, 1'b0}, '{16'hc041, 1'b0}, '{16'hc00f, 1'b0}, '{16'hc00d, 1'b0},
      '{16'hc00c, 1'b0}, '{16'hc005, 1'b0}, '{16'hc003, 1'b1}};
   logic           pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, core_stall, flash_cmd_valid;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata;
   fsp_flash_cmd_s flash_cmd, first_cmd;
   int             err_total, checks_done, ncmd, cyc;
   fsp_ctrl #(.ROW_CYCLES(100), .WORD_CYCLES(100), .ERASE_CYCLES(100)) dut (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_stall(core_stall), .flash_cmd(flash_cmd),
      .flash_cmd_valid(flash_cmd_valid));
   fsp_core_model core (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
      core.xfer(1'b0, a, 32'h0);
      check(name, core.rd_data, exp);
   endtask : rd
   // Commands are counted here so that loading can be shown to leave the array alone.
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (flash_cmd_valid === 1'b1) begin
         if (ncmd == 0) first_cmd = flash_cmd;
         ncmd = ncmd + 1;
      end
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   initial begin
      presetn     = 1'b0;
      clk_en      = 1'b1;
      ncmd        = 0;
      cyc         = 0;
      err_total   = 0;
      checks_done = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`FSP_ADDR_CONTROL, 32'h0, "control reset");
      core.xfer(1'b1, `FSP_ADDR_KEY, 32'h12aa);
      rd(`FSP_ADDR_KEY, 32'h0, "key readback");
      core.xfer(1'b0, 12'h020, 32'h0);
      check("unmapped error", {31'h0, core.rd_err}, 32'h1);
      $display("reset and register test done");
      core.xfer(1'b1, `FSP_ADDR_CONTROL, 32'h4001);
      core.xfer(1'b1, `FSP_ADDR_CONTROL, 32'hc001);
      rd(`FSP_ADDR_CONTROL, 32'h6001, "start without key");
      core.xfer(1'b1, `FSP_ADDR_KEY, 32'h55);
      core.xfer(1'b1, `FSP_ADDR_TABLE_PAGE, 32'h0);
      core.xfer(1'b1, `FSP_ADDR_KEY, 32'haa);
      core.xfer(1'b1, `FSP_ADDR_CONTROL, 32'hc001);
      rd(`FSP_ADDR_CONTROL, 32'h6001, "broken key");
      core.xfer(1'b1, `FSP_ADDR_CONTROL, 32'h0001);
      core.unlock();
      core.xfer(1'b1, `FSP_ADDR_CONTROL, 32'h8001);
      rd(`FSP_ADDR_CONTROL, 32'h2001, "write disabled");
      $display("refused start test done");
      foreach (ROWS[i]) begin
         ncmd = 0;
         core.start(ROWS[i].ctl);
         check("stall", {31'h0, core_stall}, {31'h0, ROWS[i].stall});
         rd(`FSP_ADDR_CONTROL, {16'h0, ROWS[i].ctl & 16'h7fff}, "control after op");
         check("command count", 32'(ncmd), ROWS[i].stall ? 32'h1 : 32'h0);
      end
      $display("operation select test done");
      ncmd = 0;
      core.start(16'hc003);
      clk_en <= 1'b0;
      repeat (110) @(posedge pclk);
      check("freeze holds stall", {31'h0, core_stall}, 32'h1);
      clk_en <= 1'b1;
      rd(`FSP_ADDR_CONTROL, 32'h4003, "freeze resumes");
      check("freeze command count", 32'(ncmd), 32'h1);
      $display("freeze test done");
      ncmd = 0;
      core.load_row(8'h01);
      check("buffer only", 32'(ncmd), 32'h0);
      core.start(16'hc001);
      rd(`FSP_ADDR_CONTROL, 32'h4001, "row done");
      check("row commands", 32'(ncmd), 32'd64);
      check("row address", {8'h0, first_cmd.addr}, 32'h0001_0000);
      check("row data", {8'h0, first_cmd.data}, 32'h00c1_1000);
      core.xfer(1'b1, `FSP_ADDR_TABLE_WRITE, {8'h5a, 8'h02, 16'h000a});
      rd(`FSP_ADDR_TABLE_READ, 32'h0000_105a, "byte write");
      $display("row program test done");
      end_of_test();
   end
endmodule : fsp_ctrl_tb_top
`default_nettype wire
